// File: rgb_insert_pkg.sv
// Shared constants and types for the analog RGB insertion block
package rgb_insert_pkg;

	// ==========================================================
	// Source selection
	// ==========================================================
	typedef enum logic [1:0] {
		SRC_VIDEO = 2'h0,
		SRC_EXT_A = 2'h1,
		SRC_EXT_B = 2'h3
	} source_t;

	// ==========================================================
	// Widths and reset values
	// ==========================================================
	localparam int unsigned PIX_WIDTH      = 10;
	localparam int unsigned ADJ_WIDTH      = 6;
	localparam int unsigned BRIGHT_WIDTH   = 9;
	localparam int unsigned CONTRAST_SHIFT = 5;
	localparam int unsigned STATUS_WIDTH   = 2;
	localparam int unsigned STATUS_STATIC  = 0;
	localparam int unsigned STATUS_DYNAMIC = 1;
	localparam logic        RESET_FLAG     = 1'h0;
	localparam int unsigned RESET_SYNC_LEN = 2;

endpackage

// File: key_clamp_adjust.sv
// Key clamp with per-input contrast and brightness for one colour of an external RGB set
`timescale 1ns/1ps
`default_nettype none
module key_clamp_adjust
	import rgb_insert_pkg::*;
#(
	parameter int unsigned W = PIX_WIDTH
) (
	input  wire logic                    clk,
	input  wire logic                    rstSync_b,
	input  wire logic                    clampKey,
	input  wire logic [W-1:0]            colourIn,
	input  wire logic [ADJ_WIDTH-1:0]    contrast,
	input  wire logic [BRIGHT_WIDTH-1:0] brightness,
	output logic      [W-1:0]            colourOut
);

	if (W < 2 || W > 16) begin : gBadWidth
		$error("key_clamp_adjust: unsupported width");
	end

	typedef struct packed {
		logic [W-1:0] clampLevel;
		logic [W-1:0] colourOut;
	} state_t;

	state_t state;
	state_t next_state;

	logic [W:0]                          clamped;
	logic [W+ADJ_WIDTH:0]                scaled;
	logic signed [W+ADJ_WIDTH+1:0]       shifted;

	// ==========================================================
	// Clamp, scale, offset
	// ==========================================================
	always_comb begin
		next_state = state;
		clamped    = {1'b0, colourIn} - {1'b0, state.clampLevel};
		if (clamped[W]) begin
			clamped = '0;
		end
		scaled  = (W+ADJ_WIDTH+1)'(clamped * contrast) >> CONTRAST_SHIFT;
		shifted = $signed({1'b0, scaled}) + (W+ADJ_WIDTH+2)'($signed(brightness));
		if (clampKey) begin
			next_state.clampLevel = colourIn;
		end
		if (shifted < 0) begin
			next_state.colourOut = '0;
		end else if (shifted > $signed({1'b0, {(W+ADJ_WIDTH-W+1){1'b0}}, {W{1'b1}}})) begin
			next_state.colourOut = '1;
		end else begin
			next_state.colourOut = shifted[W-1:0];
		end
	end

	always_ff @(posedge clk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign colourOut = state.colourOut;

endmodule
`default_nettype wire

// File: blank_monitor.sv
// Fast blank monitor with static level and sticky falling-edge flag
`timescale 1ns/1ps
`default_nettype none
module blank_monitor
	import rgb_insert_pkg::*;
(
	input  wire logic                    clk,
	input  wire logic                    rstSync_b,
	input  wire logic                    keyA,
	input  wire logic                    keyB,
	input  wire logic                    monitorSel,
	input  wire logic                    statusRead,
	output logic      [STATUS_WIDTH-1:0] status
);

	typedef struct packed {
		logic                    lastLevel;
		logic [STATUS_WIDTH-1:0] status;
	} state_t;

	state_t state;
	state_t next_state;
	logic   level;

	always_comb begin
		next_state = state;
		level      = monitorSel ? keyB : keyA;
		next_state.lastLevel = level;
		next_state.status[STATUS_STATIC] = level;
		// Edge wins over the read clear
		if (statusRead) begin
			next_state.status[STATUS_DYNAMIC] = RESET_FLAG;
		end
		if (state.lastLevel && !level) begin
			next_state.status[STATUS_DYNAMIC] = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign status = state.status;

endmodule
`default_nettype wire

// File: rgb_insertion_fast_blank_select.sv
// Top of the analog RGB insertion, fast blank select and half contrast block
// Operation
// - Two external RGB inputs, each key-clamped, merged by the fast blank switch.
// - Polarity 0: none high video, one high that input, both high by priority.
// - Polarity 1: both low by priority, one low that input, both high video.
// - Table selection uses the key levels after the four force settings are applied.
// - Selected external input is placed over or under the digital overlay by extOverOverlay.
// - Separate brightness and contrast for each external input.
// - Two-bit monitor status; static bit is the monitored line level.
// - Dynamic bit is a flip-flop set by a falling edge of the line.
// - Monitor watches input A or B by a select setting.
// - Half contrast reduces video background only; inserted RGB keeps full contrast.
// - Half contrast drops output level to half.
`timescale 1ns/1ps
`default_nettype none
module rgb_insertion_fast_blank_select
	import rgb_insert_pkg::*;
#(
	parameter int unsigned W = PIX_WIDTH
) (
	input  wire logic                    clk,
	input  wire logic                    rst_b,
	input  wire logic                    clampKey,
	input  wire logic [W-1:0]            videoRed,
	input  wire logic [W-1:0]            videoGreen,
	input  wire logic [W-1:0]            videoBlue,
	input  wire logic                    videoOverlay,
	input  wire logic [W-1:0]            overlayRed,
	input  wire logic [W-1:0]            overlayGreen,
	input  wire logic [W-1:0]            overlayBlue,
	input  wire logic                    extOverOverlay,
	input  wire logic [W-1:0]            extRedInA,
	input  wire logic [W-1:0]            extGreenInA,
	input  wire logic [W-1:0]            extBlueInA,
	input  wire logic [W-1:0]            extRedInB,
	input  wire logic [W-1:0]            extGreenInB,
	input  wire logic [W-1:0]            extBlueInB,
	input  wire logic                    blankKeyInA,
	input  wire logic                    blankKeyInB,
	input  wire logic                    blankKeyPolaritySel,
	input  wire logic                    overlayPrioritySel,
	input  wire logic                    keyAForceHigh,
	input  wire logic                    keyBForceHigh,
	input  wire logic                    keyAForceLow,
	input  wire logic                    keyBForceLow,
	input  wire logic [ADJ_WIDTH-1:0]    contrastA,
	input  wire logic [BRIGHT_WIDTH-1:0] brightnessA,
	input  wire logic [ADJ_WIDTH-1:0]    contrastB,
	input  wire logic [BRIGHT_WIDTH-1:0] brightnessB,
	input  wire logic                    halfContrastIn,
	input  wire logic                    halfContrastEnable,
	input  wire logic                    halfContrastForceHigh,
	input  wire logic                    monitorSel,
	input  wire logic                    statusRead,
	output logic      [STATUS_WIDTH-1:0] monitorStatus,
	output logic      [W-1:0]            rgbRed,
	output logic      [W-1:0]            rgbGreen,
	output logic      [W-1:0]            rgbBlue,
	output logic      [1:0]              selectedSource
);

	if (W < 2 || W > 16) begin : gBadWidth
		$error("rgb_insertion_fast_blank_select: unsupported width");
	end

	if (RESET_SYNC_LEN < 2) begin : gBadSync
		$error("rgb_insertion_fast_blank_select: reset release needs two stages");
	end

	if (STATUS_STATIC >= STATUS_WIDTH || STATUS_DYNAMIC >= STATUS_WIDTH) begin : gBadStatus
		$error("rgb_insertion_fast_blank_select: status bit outside field");
	end

	// ==========================================================
	// Reset release
	// ==========================================================
	logic [RESET_SYNC_LEN-1:0] rstPipe;
	logic                      rstSync_b;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rstPipe <= '0;
		end else begin
			rstPipe <= {rstPipe[RESET_SYNC_LEN-2:0], 1'b1};
		end
	end

	assign rstSync_b = rstPipe[RESET_SYNC_LEN-1];

	// ==========================================================
	// External inputs: clamp and adjust
	// ==========================================================
	logic [W-1:0] adjA [3];
	logic [W-1:0] adjB [3];

	// Set A
	key_clamp_adjust #(
		.W (W)
	) uClampRedA (
		.clk        (clk),
		.rstSync_b  (rstSync_b),
		.clampKey   (clampKey),
		.colourIn   (extRedInA),
		.contrast   (contrastA),
		.brightness (brightnessA),
		.colourOut  (adjA[0])
	);

	key_clamp_adjust #(
		.W (W)
	) uClampGreenA (
		.clk        (clk),
		.rstSync_b  (rstSync_b),
		.clampKey   (clampKey),
		.colourIn   (extGreenInA),
		.contrast   (contrastA),
		.brightness (brightnessA),
		.colourOut  (adjA[1])
	);

	key_clamp_adjust #(
		.W (W)
	) uClampBlueA (
		.clk        (clk),
		.rstSync_b  (rstSync_b),
		.clampKey   (clampKey),
		.colourIn   (extBlueInA),
		.contrast   (contrastA),
		.brightness (brightnessA),
		.colourOut  (adjA[2])
	);

	// Set B
	key_clamp_adjust #(
		.W (W)
	) uClampRedB (
		.clk        (clk),
		.rstSync_b  (rstSync_b),
		.clampKey   (clampKey),
		.colourIn   (extRedInB),
		.contrast   (contrastB),
		.brightness (brightnessB),
		.colourOut  (adjB[0])
	);

	key_clamp_adjust #(
		.W (W)
	) uClampGreenB (
		.clk        (clk),
		.rstSync_b  (rstSync_b),
		.clampKey   (clampKey),
		.colourIn   (extGreenInB),
		.contrast   (contrastB),
		.brightness (brightnessB),
		.colourOut  (adjB[1])
	);

	key_clamp_adjust #(
		.W (W)
	) uClampBlueB (
		.clk        (clk),
		.rstSync_b  (rstSync_b),
		.clampKey   (clampKey),
		.colourIn   (extBlueInB),
		.contrast   (contrastB),
		.brightness (brightnessB),
		.colourOut  (adjB[2])
	);

	// ==========================================================
	// Fast blank monitor
	// ==========================================================
	blank_monitor uMonitor (
		.clk        (clk),
		.rstSync_b  (rstSync_b),
		.keyA       (blankKeyInA),
		.keyB       (blankKeyInB),
		.monitorSel (monitorSel),
		.statusRead (statusRead),
		.status     (monitorStatus)
	);

	// ==========================================================
	// Fast blank decode
	// ==========================================================
	source_t extSel;
	logic    keyA;
	logic    keyB;
	logic    useExt;

	always_comb begin
		// Force settings override the line levels; both sources rely on matched polarity
		keyA   = (blankKeyInA | keyAForceHigh) & ~keyAForceLow;
		keyB   = (blankKeyInB | keyBForceHigh) & ~keyBForceLow;
		extSel = SRC_VIDEO;
		case ({blankKeyPolaritySel, keyA, keyB, overlayPrioritySel})
			4'h0: extSel = SRC_VIDEO;
			4'h1: extSel = SRC_VIDEO;
			4'h2: extSel = SRC_EXT_B;
			4'h3: extSel = SRC_EXT_B;
			4'h4: extSel = SRC_EXT_A;
			4'h5: extSel = SRC_EXT_A;
			4'h6: extSel = SRC_EXT_A;
			4'h7: extSel = SRC_EXT_B;
			4'h8: extSel = SRC_EXT_A;
			4'h9: extSel = SRC_EXT_B;
			4'hA: extSel = SRC_EXT_A;
			4'hB: extSel = SRC_EXT_A;
			4'hC: extSel = SRC_EXT_B;
			4'hD: extSel = SRC_EXT_B;
			4'hE: extSel = SRC_VIDEO;
			4'hF: extSel = SRC_VIDEO;
			default: extSel = SRC_VIDEO;
		endcase
		useExt = (extSel != SRC_VIDEO);
	end

	// ==========================================================
	// Digital picture
	// ==========================================================
	logic [W-1:0] bgRed;
	logic [W-1:0] bgGreen;
	logic [W-1:0] bgBlue;

	always_comb begin
		// Overlay over video; the overlay never takes half contrast
		bgRed   = videoRed;
		bgGreen = videoGreen;
		bgBlue  = videoBlue;
		if (videoOverlay) begin
			bgRed   = overlayRed;
			bgGreen = overlayGreen;
			bgBlue  = overlayBlue;
		end
	end

	// ==========================================================
	// Selection and output stage
	// ==========================================================
	typedef struct packed {
		source_t      source;
		logic [W-1:0] red;
		logic [W-1:0] green;
		logic [W-1:0] blue;
	} state_t;

	state_t state;
	state_t next_state;

	logic extWins;
	logic halfOn;
	logic bgHalf;

	always_comb begin
		next_state = state;
		// External RGB over or under the digital overlay
		extWins = useExt && (extOverOverlay || !videoOverlay);
		// Half contrast, applied to video background only
		halfOn = halfContrastForceHigh || (halfContrastEnable && halfContrastIn);
		bgHalf = halfOn && !videoOverlay;
		if (extWins) begin
			next_state.source = extSel;
			if (extSel == SRC_EXT_B) begin
				next_state.red   = adjB[0];
				next_state.green = adjB[1];
				next_state.blue  = adjB[2];
			end else begin
				next_state.red   = adjA[0];
				next_state.green = adjA[1];
				next_state.blue  = adjA[2];
			end
		end else begin
			next_state.source = SRC_VIDEO;
			if (bgHalf) begin
				next_state.red   = bgRed >> 1;
				next_state.green = bgGreen >> 1;
				next_state.blue  = bgBlue >> 1;
			end else begin
				next_state.red   = bgRed;
				next_state.green = bgGreen;
				next_state.blue  = bgBlue;
			end
		end
	end

	always_ff @(posedge clk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			state <= '{source: SRC_VIDEO, default: '0};
		end else begin
			state <= next_state;
		end
	end

	assign rgbRed         = state.red;
	assign rgbGreen       = state.green;
	assign rgbBlue        = state.blue;
	assign selectedSource = state.source;

endmodule
`default_nettype wire

// File: rgb_source_model.sv
// Behavioural external RGB source with two colour sets and their key lines
`timescale 1ns/1ps
`default_nettype none
module rgb_source_model
	import rgb_insert_pkg::*;
(
	input  wire logic		blankKeyPolaritySel,
	input  wire logic		actA,
	input  wire logic		actB,
	input  wire logic		black,
	output logic			blankKeyInA,
	output logic			blankKeyInB,
	output logic [PIX_WIDTH-1:0]	extRedInA,
	output logic [PIX_WIDTH-1:0]	extGreenInA,
	output logic [PIX_WIDTH-1:0]	extBlueInA,
	output logic [PIX_WIDTH-1:0]	extRedInB,
	output logic [PIX_WIDTH-1:0]	extGreenInB,
	output logic [PIX_WIDTH-1:0]	extBlueInB
);
	// One shared polarity; callers move the controls only at the flyback edge
	assign blankKeyInA = actA ^ blankKeyPolaritySel;
	assign blankKeyInB = actB ^ blankKeyPolaritySel;
	// Black level while the clamp key is open
	assign {extRedInA, extGreenInA, extBlueInA} = black ? '0 : {10'h100, 10'h101, 10'h102};
	assign {extRedInB, extGreenInB, extBlueInB} = black ? '0 : {10'h200, 10'h201, 10'h202};
endmodule
`default_nettype wire

// File: rgb_insert_chk.sv
// Port-level assertions for the RGB insertion block
`timescale 1ns/1ps
`default_nettype none
module rgb_insert_chk
	import rgb_insert_pkg::*;
#(
	parameter int unsigned W = PIX_WIDTH
) (
	input wire logic		clk,
	input wire logic		rst_b,
	input wire logic [W-1:0]	videoRed,
	input wire logic		videoOverlay,
	input wire logic		extOverOverlay,
	input wire logic		blankKeyInA,
	input wire logic		blankKeyInB,
	input wire logic		blankKeyPolaritySel,
	input wire logic		overlayPrioritySel,
	input wire logic		keyAForceHigh,
	input wire logic		keyBForceHigh,
	input wire logic		keyAForceLow,
	input wire logic		keyBForceLow,
	input wire logic		halfContrastIn,
	input wire logic		halfContrastEnable,
	input wire logic		halfContrastForceHigh,
	input wire logic		monitorSel,
	input wire logic		statusRead,
	input wire logic [1:0]		monitorStatus,
	input wire logic [W-1:0]	rgbRed,
	input wire logic [1:0]		selectedSource
);
	logic [1:0]	cnt;
	logic [1:0]	expSel;
	logic		ready, aAct, bAct, monLine, half, plain;
	// Edges since release; outputs follow inputs from the third on
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
			cnt <= 2'h0;
		else if (!ready)
			cnt <= cnt + 2'h1;
	assign ready = cnt == 2'h3;
	assign aAct = blankKeyInA ^ blankKeyPolaritySel;
	assign bAct = blankKeyInB ^ blankKeyPolaritySel;
	assign expSel = (bAct & (~aAct | overlayPrioritySel)) ? 2'h3 : {1'h0, aAct};
	assign monLine = monitorSel ? blankKeyInB : blankKeyInA;
	assign half = halfContrastForceHigh | (halfContrastEnable & halfContrastIn);
	assign plain = ready && !(keyAForceHigh | keyBForceHigh | keyAForceLow | keyBForceLow) && expSel == 2'h0;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	a_sel_table: assert property (ready && !(keyAForceHigh | keyBForceHigh | keyAForceLow | keyBForceLow)
		|=> selectedSource == ($past(videoOverlay & ~extOverOverlay) ? 2'h0 : $past(expSel)))
		else $error("source mismatch");
	a_video_full: assert property (plain && !videoOverlay && !half |=> rgbRed == $past(videoRed))
		else $error("video level wrong");
	a_video_half: assert property (plain && !videoOverlay && half |=> rgbRed == ($past(videoRed) >> 1))
		else $error("half level wrong");
	a_mon_level: assert property (ready |=> monitorStatus[0] == $past(monLine))
		else $error("static bit wrong");
	a_flag_set: assert property (ready && $fell(monLine) && $stable(monitorSel) |=> monitorStatus[1])
		else $error("flag not set");
	a_flag_clear: assert property (ready && statusRead && !$fell(monLine) |=> !monitorStatus[1])
		else $error("flag not cleared");
	a_flag_hold: assert property (ready && monitorStatus[1] && !statusRead |=> monitorStatus[1])
		else $error("flag lost");
	a_flag_quiet: assert property (ready && !monitorStatus[1] && !$fell(monLine) && $stable(monitorSel)
		|=> !monitorStatus[1]) else $error("flag set without edge");
	c_flag: cover property (ready && $fell(monLine));
	c_half: cover property (plain && half);
	c_ext_b: cover property (selectedSource == 2'h3);
endmodule
bind rgb_insertion_fast_blank_select rgb_insert_chk #(.W(W)) chk (.*);
`default_nettype wire

// File: tb.sv
// Self-checking bench for the RGB insertion block
`timescale 1ns/1ps
`default_nettype none
module tb
	import rgb_insert_pkg::*;
;
	logic clk, rst_b, clampKey, videoOverlay, extOverOverlay, blankKeyInA, blankKeyInB, blankKeyPolaritySel, actA, actB;
	logic overlayPrioritySel, keyAForceHigh, keyBForceHigh, keyAForceLow, keyBForceLow, halfContrastIn, black;
	logic halfContrastEnable, halfContrastForceHigh, monitorSel, statusRead;
	logic [PIX_WIDTH-1:0] videoRed, videoGreen, videoBlue, overlayRed, overlayGreen, overlayBlue, rgbRed, rgbGreen;
	logic [PIX_WIDTH-1:0] rgbBlue, extRedInA, extGreenInA, extBlueInA, extRedInB, extGreenInB, extBlueInB, base;
	logic [ADJ_WIDTH-1:0] contrastA, contrastB;
	logic [BRIGHT_WIDTH-1:0] brightnessA, brightnessB;
	logic [1:0] monitorStatus, selectedSource, e;
	int bad_count, cmp_count;

	rgb_insertion_fast_blank_select dut (.*);
	rgb_source_model ext (.*);

	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end

	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic check(input logic [PIX_WIDTH-1:0] got, exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic cmpSrc(input logic [1:0] x);
		tick(4);
		check(PIX_WIDTH'(selectedSource), PIX_WIDTH'(x));
	endtask
	task automatic cmpSt(input logic [1:0] x);
		tick(3);
		check(PIX_WIDTH'(monitorStatus), PIX_WIDTH'(x));
	endtask
	task automatic cmpRgb(input logic [PIX_WIDTH-1:0] r, g, b);
		tick(4);
		check(rgbRed, r);
		check(rgbGreen, g);
		check(rgbBlue, b);
	endtask
	task automatic readPulse();
		statusRead = 1'h1;
		tick(1);
		statusRead = 1'h0;
	endtask
	task automatic test_done();
		$display("compares %0d, mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		{bad_count, cmp_count} = '0;
		{rst_b, videoOverlay, extOverOverlay, blankKeyPolaritySel, overlayPrioritySel, actA, actB, halfContrastIn} = '0;
		{keyAForceHigh, keyBForceHigh, keyAForceLow, keyBForceLow, halfContrastEnable, halfContrastForceHigh} = '0;
		{monitorSel, statusRead, clampKey, black} = 4'h3;
		{videoRed, videoGreen, videoBlue} = {10'h300, 10'h301, 10'h302};
		{overlayRed, overlayGreen, overlayBlue} = {10'h050, 10'h051, 10'h052};
		{contrastA, contrastB, brightnessA, brightnessB} = {6'h20, 6'h20, 18'h0};
		tick(2);
		rst_b = 1'h1;
		tick(5);
		{clampKey, black} = 2'h0;
		for (int i = 0; i < 16; i++) begin
			{blankKeyPolaritySel, overlayPrioritySel, actA, actB} = 4'(i);
			e = (actB & (~actA | overlayPrioritySel)) ? 2'h3 : {1'h0, actA};
			base = (e == 2'h3) ? 10'h200 : (e == 2'h1) ? 10'h100 : 10'h300;
			cmpSrc(e);
			cmpRgb(base, base + 10'h1, base + 10'h2);
		end
		{blankKeyPolaritySel, actA, actB, keyAForceHigh} = 4'h1;
		cmpSrc(2'h1);
		{keyAForceLow, keyBForceHigh} = 2'h3;
		cmpSrc(2'h3);
		{actB, keyBForceLow} = 2'h3;
		cmpSrc(2'h0);
		{keyAForceHigh, keyBForceHigh, keyAForceLow, keyBForceLow, actB, videoOverlay} = 6'h1;
		cmpRgb(10'h050, 10'h051, 10'h052);
		actA = 1'h1;
		cmpRgb(10'h050, 10'h051, 10'h052);
		extOverOverlay = 1'h1;
		cmpRgb(10'h100, 10'h101, 10'h102);
		clampKey = 1'h1;
		cmpRgb(10'h000, 10'h000, 10'h000);
		clampKey = 1'h0;
		cmpRgb(10'h000, 10'h000, 10'h000);
		{clampKey, black} = 2'h3;
		cmpRgb(10'h000, 10'h000, 10'h000);
		{clampKey, black} = 2'h0;
		cmpRgb(10'h100, 10'h101, 10'h102);
		{videoOverlay, brightnessA, contrastB} = {1'h0, 9'h010, 6'h10};
		cmpRgb(10'h110, 10'h111, 10'h112);
		{actA, actB} = 2'h1;
		cmpRgb(10'h100, 10'h100, 10'h101);
		{actB, brightnessA, contrastB, halfContrastIn} = {1'h0, 9'h0, 6'h20, 1'h1};
		cmpRgb(10'h300, 10'h301, 10'h302);
		halfContrastEnable = 1'h1;
		cmpRgb(10'h180, 10'h180, 10'h181);
		actA = 1'h1;
		cmpRgb(10'h100, 10'h101, 10'h102);
		{actA, halfContrastEnable, halfContrastForceHigh} = 3'h1;
		cmpRgb(10'h180, 10'h180, 10'h181);
		{halfContrastIn, halfContrastForceHigh} = 2'h0;
		readPulse();
		cmpSt(2'h0);
		actA = 1'h1;
		cmpSt(2'h1);
		actA = 1'h0;
		cmpSt(2'h2);
		readPulse();
		cmpSt(2'h0);
		{monitorSel, actA} = 2'h3;
		cmpSt(2'h0);
		actA = 1'h0;
		cmpSt(2'h0);
		actB = 1'h1;
		cmpSt(2'h1);
		actB = 1'h0;
		cmpSt(2'h2);
		test_done();
	end
endmodule
`default_nettype wire
